// [hdl/scp_pkg.sv]
// ==========================================================
// system control register bank constants
package scp_pkg;

  // ========================================================
  // bank geometry
  localparam int NRW = 30; // number of read/write words
  localparam int IXW = 5; // width of a word index
  localparam int WAKE_W = 13; // start logic wake inputs
  localparam int AW = 12; // byte offset width

  // ========================================================
  // offsets of the read/write words, index 0 first
  localparam logic [0:NRW-1][AW-1:0] RW_OFS = {
    12'h000, 12'h004, 12'h008, 12'h020, 12'h024, 12'h028,
    12'h030, 12'h040, 12'h044, 12'h070, 12'h074, 12'h078,
    12'h080, 12'h094, 12'h098, 12'h09c, 12'h0d0, 12'h0d4,
    12'h0d8, 12'h0e0, 12'h0e4, 12'h0e8, 12'h150, 12'h154,
    12'h174, 12'h200, 12'h204, 12'h230, 12'h234, 12'h238};

  // reset values of the read/write words
  localparam logic [0:NRW-1][31:0] RW_RST = {
    32'h0000_0002, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0080,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0001,
    32'h0000_085f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0004,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_edf0, 32'h0000_edf0};

  // implemented bits of each word, the rest read zero
  localparam logic [0:NRW-1][31:0] RW_MASK = {
    32'h0000_0003, 32'h0000_000f, {23{32'hffff_ffff}},
    32'h0000_1fff, 32'h0000_1fff, {3{32'hffff_ffff}}};

  // ========================================================
  // indices of words that steer logic
  localparam logic [IXW-1:0] IX_VEC = 5'h00;
  localparam logic [IXW-1:0] IX_PRESET = 5'h01;
  localparam logic [IXW-1:0] IX_PLL = 5'h02;
  localparam logic [IXW-1:0] IX_BUSDIV = 5'h0b;
  localparam logic [IXW-1:0] IX_GATES = 5'h0c;
  localparam logic [IXW-1:0] IX_WPOL = 5'h19;
  localparam logic [IXW-1:0] IX_WEN = 5'h1a;
  localparam logic [IXW-1:0] IX_SLEEPPD = 5'h1b;
  localparam logic [IXW-1:0] IX_WAKEPD = 5'h1c;
  localparam logic [IXW-1:0] IX_RUNPD = 5'h1d;
  // choice words: pll input, core, watchdog, clock pin
  localparam logic [0:3][IXW-1:0] CHOICE_IX = {
    5'h07, 5'h09, 5'h10, 5'h13};

  // ========================================================
  // offsets outside the read/write array
  localparam logic [AW-1:0] OFS_PLL_LOCK = 12'h00c;
  localparam logic [AW-1:0] OFS_SNAP_LO = 12'h100;
  localparam logic [AW-1:0] OFS_SNAP_HI = 12'h104;
  localparam logic [AW-1:0] OFS_WAKE_CLR = 12'h208;
  localparam logic [AW-1:0] OFS_WAKE_STATE = 12'h20c;
  localparam logic [AW-1:0] OFS_PART_ID = 12'h3f4;

  // ========================================================
  // vector origin encodings
  localparam logic [1:0] VEC_BOOT_ROM = 2'h0;
  localparam logic [1:0] VEC_SRAM = 2'h1;
  localparam logic [1:0] VEC_FLASH = 2'h2;
  localparam int OVERLAY_BYTES = 512; // overlaid range size

  // ========================================================
  // whole state of the bank
  typedef struct packed {
    logic [0:NRW-1][31:0] rw; // index 0 first, like the tables
    logic [31:0] rdata;
    logic ready;
    logic [WAKE_W-1:0] wake_prev;
    logic [WAKE_W-1:0] wake_latch;
    logic [31:0] snap_lo;
    logic [31:0] snap_hi;
    logic snap_done;
    logic pll_lock;
    logic [3:0][1:0] src_active;
    logic rom_ov;
    logic ram_ov;
  } scp_state_t;

endpackage

// [hdl/scp_regbank.sv]
// Overview of operation
// - every register sits on its own aligned 32-bit word.
// - the vector origin field picks boot rom, flash or sram vectors.
// - after reset the vector origin reads 0x002, flash at zero.
// - origin 0x0 overlays boot rom, 0x1 sram, on the low 512 bytes.
// - two read-only snapshots hold the pin levels seen at power-on.
// - the wake latch clear word at 0x208 is write-only.
// - the wake latch state at 0x20c shows which wake inputs fired.
// - the bus clock gates reset to 0x85f.
// - run and wake-up power-down sets reset to edf0, deep-sleep to 0.
// - bus divider resets to 0x001, rc trim to 0x080, the word at 0x154 to 0x004, others to 0.
// - a read-only part identity word exists on some variants only.
// - each clock choice word has a commit word right after it.
// - origin 0x2 leaves the vectors in flash, the reset state.
// - a zero release bit holds its peripheral in reset.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module scp_regbank #(
  parameter logic [31:0] PART_ID = 32'h0000_5a5a, // arbitrary value
  parameter bit PART_ID_PRESENT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scp_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_locked,
  input wire logic [31:0] por_pins_lo,
  input wire logic [31:0] por_pins_hi,
  input wire logic [scp_pkg::WAKE_W-1:0] wake_pins,
  output logic rom_overlay,
  output logic ram_overlay,
  output logic [1:0] vector_origin,
  output logic [3:0] periph_release,
  output logic [6:0] pll_setup,
  output logic [7:0] bus_clock_div,
  output logic [31:0] bus_clock_gates,
  output logic [31:0] run_powerdown,
  output logic [31:0] wakeup_powerdown,
  output logic [31:0] deepsleep_powerdown,
  output logic [1:0] pll_src,
  output logic [1:0] core_src,
  output logic [1:0] wdt_src,
  output logic [1:0] clkpin_src
);
  import scp_pkg::*;

  // ========================================================
  // address decode of the read/write array
  function automatic logic [IXW:0] find_ix(
    input logic [AW-1:0] a
  );
    logic [IXW:0] r;
    r = '0;
    for (int i = 0; i < NRW; i++) begin
      if ({a[AW-1:2], 2'b00} == RW_OFS[i]) begin
        r = {1'b1, i[IXW-1:0]};
      end
    end
    return r;
  endfunction

  // word-aligned compare for single offsets
  function automatic logic at_ofs(
    input logic [AW-1:0] a,
    input logic [AW-1:0] o
  );
    return {a[AW-1:2], 2'b00} == o;
  endfunction

  // ========================================================
  // state and its next value
  scp_state_t cur_ff;
  scp_state_t nxt_cur;

  logic [IXW:0] dec;
  logic hit;
  logic [IXW-1:0] ix;
  logic setup_rd;
  logic wr;
  logic [31:0] rd_word;
  logic [WAKE_W-1:0] rise;
  logic [WAKE_W-1:0] fall;
  logic [WAKE_W-1:0] wake_ev;
  logic [WAKE_W-1:0] wake_clr;
  logic [IXW-1:0] cmt;

  // ========================================================
  // next state
  always_comb begin
    nxt_cur = cur_ff;
    dec = find_ix(paddr);
    hit = dec[IXW];
    ix = dec[IXW-1:0];
    setup_rd = psel & ~penable & ~pwrite;
    wr = psel & penable & cur_ff.ready & pwrite;
    cmt = '0;

    // read mux, unmapped and write-only offsets give zero
    rd_word = '0;
    if (hit) begin
      rd_word = cur_ff.rw[ix] & RW_MASK[ix];
    end else if (at_ofs(paddr, OFS_PLL_LOCK)) begin
      rd_word = {31'h0, cur_ff.pll_lock};
    end else if (at_ofs(paddr, OFS_SNAP_LO)) begin
      rd_word = cur_ff.snap_lo;
    end else if (at_ofs(paddr, OFS_SNAP_HI)) begin
      rd_word = cur_ff.snap_hi;
    end else if (at_ofs(paddr, OFS_WAKE_STATE)) begin
      rd_word = {{(32-WAKE_W){1'b0}}, cur_ff.wake_latch};
    end else if (at_ofs(paddr, OFS_PART_ID) && PART_ID_PRESENT) begin
      rd_word = PART_ID;
    end

    // apb answer: ready in the first access cycle
    nxt_cur.ready = psel & ~penable;
    if (setup_rd) begin
      nxt_cur.rdata = rd_word;
    end else if (!psel) begin
      nxt_cur.rdata = '0;
    end

    // commit words: a 0 to 1 on bit 0 applies the choice
    for (int k = 0; k < 4; k++) begin
      cmt = CHOICE_IX[k] + 5'h01;
      if (wr && hit && ix == cmt && pwdata[0] &&
          !cur_ff.rw[cmt][0]) begin
        nxt_cur.src_active[k] = cur_ff.rw[CHOICE_IX[k]][1:0];
      end
    end

    // store a write; only the array holds written values
    if (wr && hit) begin
      nxt_cur.rw[ix] = pwdata & RW_MASK[ix];
    end

    // wake start logic: edge per polarity, gated by enable
    rise = wake_pins & ~cur_ff.wake_prev;
    fall = ~wake_pins & cur_ff.wake_prev;
    wake_ev = cur_ff.rw[IX_WEN][WAKE_W-1:0] &
      ((cur_ff.rw[IX_WPOL][WAKE_W-1:0] & rise) |
       (~cur_ff.rw[IX_WPOL][WAKE_W-1:0] & fall));
    wake_clr = '0;
    if (wr && at_ofs(paddr, OFS_WAKE_CLR)) begin
      wake_clr = pwdata[WAKE_W-1:0];
    end
    // a new edge wins over a clear in the same cycle
    nxt_cur.wake_latch = (cur_ff.wake_latch & ~wake_clr) |
      wake_ev;
    nxt_cur.wake_prev = wake_pins;

    // pll lock and power-on snapshot after reset release
    nxt_cur.pll_lock = pll_locked;
    if (!cur_ff.snap_done) begin
      nxt_cur.snap_lo = por_pins_lo;
      nxt_cur.snap_hi = por_pins_hi;
      nxt_cur.snap_done = 1'b1;
    end

    // vector overlay of the lowest bytes
    nxt_cur.rom_ov = nxt_cur.rw[IX_VEC][1:0] == VEC_BOOT_ROM;
    nxt_cur.ram_ov = nxt_cur.rw[IX_VEC][1:0] == VEC_SRAM;
  end

  // ========================================================
  // state register, array reset values from the constant tables, the rest zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
      cur_ff.rw <= RW_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ========================================================
  // outputs, all but pslverr taken from the state register
  assign prdata = cur_ff.rdata;
  assign pready = cur_ff.ready;
  assign pslverr = 1'b0;
  assign rom_overlay = cur_ff.rom_ov;
  assign ram_overlay = cur_ff.ram_ov;
  assign vector_origin = cur_ff.rw[IX_VEC][1:0];
  assign periph_release = cur_ff.rw[IX_PRESET][3:0];
  assign pll_setup = cur_ff.rw[IX_PLL][6:0];
  assign bus_clock_div = cur_ff.rw[IX_BUSDIV][7:0];
  assign bus_clock_gates = cur_ff.rw[IX_GATES];
  assign run_powerdown = cur_ff.rw[IX_RUNPD];
  assign wakeup_powerdown = cur_ff.rw[IX_WAKEPD];
  assign deepsleep_powerdown = cur_ff.rw[IX_SLEEPPD];
  assign pll_src = cur_ff.src_active[0];
  assign core_src = cur_ff.src_active[1];
  assign wdt_src = cur_ff.src_active[2];
  assign clkpin_src = cur_ff.src_active[3];

endmodule

// [verification/scp_regbank_sva.sv]
`timescale 1ns/1ps
// ====================================
// bus timing and remap checks
module scp_regbank_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scp_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic rom_overlay,
  input wire logic ram_overlay,
  input wire logic [1:0] vector_origin,
  input wire logic [31:0] bus_clock_gates
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // completed access
  wire logic acc = psel && penable && pready;
  a_ready_setup:
    assert property (psel && !penable |=> pready) else $error("late ready");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held");
  a_rom_overlay:
    assert property ($stable(vector_origin) |->
      rom_overlay == (vector_origin == 2'h0)) else $error("rom overlay");
  a_ram_overlay:
    assert property ($stable(vector_origin) |->
      ram_overlay == (vector_origin == 2'h1)) else $error("ram overlay");
  a_flash_plain:
    assert property (vector_origin == 2'h2 && $stable(vector_origin) |->
      !rom_overlay && !ram_overlay) else $error("flash overlaid");
  a_reserved_zero:
    assert property (acc && !pwrite && paddr inside {[12'h010:12'h01c]} |->
      prdata == 32'h0) else $error("reserved read");
  a_clear_zero:
    assert property (acc && !pwrite && paddr == 12'h208 |->
      prdata == 32'h0) else $error("clear word read");
  a_gates_write:
    assert property (acc && pwrite && paddr == 12'h080 |=>
      bus_clock_gates == $past(pwdata)) else $error("gates write");
endmodule
bind scp_regbank scp_regbank_sva u_sva (.clk_sys, .reset_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .rom_overlay,
  .ram_overlay, .vector_origin, .bus_clock_gates);

// [verification/test_system_control_register_map.sv]
`timescale 1ns/1ps
module test_system_control_register_map;
  import scp_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pll_locked = 1'b1, pready, rom_overlay, ram_overlay;
  logic [AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, bus_clock_gates;
  logic [WAKE_W-1:0] wake_pins = 13'h0;
  logic [1:0] vector_origin;
  logic [3:0] periph_release;
  logic [3:0][1:0] srcs;
  logic [31:0] run_pd, wake_pd, sleep_pd;
  logic [6:0] pll_setup;
  logic [7:0] bus_clock_div;
  logic pslverr;
  int bad_count = 0, comparisons = 0;
  // part identity value is arbitrary
  scp_regbank #(.PART_ID(32'h0000_1234), .PART_ID_PRESENT(1'b1)) u_dut (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pll_locked, .por_pins_lo(32'h0000_a5c3),
    .por_pins_hi(32'h0000_3c5a), .wake_pins, .rom_overlay, .ram_overlay,
    .vector_origin, .periph_release, .pll_setup, .bus_clock_div,
    .bus_clock_gates, .run_powerdown(run_pd), .wakeup_powerdown(wake_pd),
    .deepsleep_powerdown(sleep_pd), .pll_src(srcs[0]), .core_src(srcs[1]),
    .wdt_src(srcs[2]), .clkpin_src(srcs[3]));
  // ====================================
  // shared tasks
  task automatic finish_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, waits for ready under a bound
  task automatic apb(logic w, logic [AW-1:0] a, logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("pready", 32'h1, 32'h0);
        finish_test();
      end
      @(posedge clk_sys);
    end
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ====================================
  // scenarios
  task automatic t_resets();
    logic [AW-1:0] a [9] = '{12'h000, 12'h004, 12'h028, 12'h078, 12'h080,
      12'h154, 12'h230, 12'h234, 12'h238};
    logic [31:0] e [9] = '{32'h2, 32'h0, 32'h80, 32'h1, 32'h85f, 32'h4,
      32'h0, 32'hedf0, 32'hedf0};
    chk("origin pin", 32'h2, {30'h0, vector_origin});
    chk("run pd pin", 32'hedf0, run_pd);
    chk("wake pd pin", 32'hedf0, wake_pd);
    chk("sleep pd pin", 32'h0, sleep_pd);
    chk("pll pin", 32'h0, {25'h0, pll_setup});
    chk("bus div pin", 32'h1, {24'h0, bus_clock_div});
    chk("gates rst pin", 32'h85f, bus_clock_gates);
    chk("slave error", 32'h0, {31'h0, pslverr});
    chk("overlay rst", 32'h0, {30'h0, ram_overlay, rom_overlay});
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0, r);
      chk("reset word", e[i], r);
    end
  endtask
  task automatic t_writes();
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h000, 32'(m), r);
      @(posedge clk_sys);
      apb(1'b0, 12'h000, 32'h0, r);
      chk("origin", 32'(m), r);
      chk("overlay", {30'h0, m == 1, m == 0},
        {30'h0, ram_overlay, rom_overlay});
    end
    apb(1'b1, 12'h004, 32'hf, r);
    chk("release", 32'hf, {28'h0, periph_release});
    apb(1'b1, 12'h080, 32'h1234_5678, r);
    chk("gates pin", 32'h1234_5678, bus_clock_gates);
  endtask
  task automatic t_refuse();
    logic [AW-1:0] a [6] = '{12'h010, 12'h208, 12'h00c, 12'h100, 12'h104,
      12'h3f4};
    logic [31:0] e [6] = '{32'h0, 32'h0, 32'h1, 32'ha5c3, 32'h3c5a,
      32'h1234};
    foreach (a[i]) apb(1'b1, a[i], 32'hffff_ffff, r);
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0, r);
      chk("fixed word", e[i], r);
    end
  endtask
  task automatic t_commit();
    logic [AW-1:0] a [4] = '{12'h040, 12'h070, 12'h0d0, 12'h0e0};
    foreach (a[i]) begin
      apb(1'b1, a[i], 32'((i % 3) + 1), r);
      chk("held source", 32'h0, {30'h0, srcs[i]});
      apb(1'b1, a[i] + 12'h004, 32'h1, r);
      repeat (2) @(posedge clk_sys);
      chk("source", 32'((i % 3) + 1), {30'h0, srcs[i]});
    end
  endtask
  task automatic t_wake();
    apb(1'b1, 12'h200, 32'h1, r);
    apb(1'b1, 12'h204, 32'h1, r);
    wake_pins <= 13'h1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 12'h20c, 32'h0, r);
    chk("wake latch", 32'h1, r);
    apb(1'b1, 12'h208, 32'h1, r);
    apb(1'b0, 12'h20c, 32'h0, r);
    chk("wake cleared", 32'h0, r);
  endtask
  // clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_resets();
    t_writes();
    t_refuse();
    t_commit();
    t_wake();
    finish_test();
  end
endmodule
